// File: logic/dmsps_pkg.sv
`default_nettype none
package dmsps_pkg;

	// ------------------------------------------------------------
	// Memory sizes
	// ------------------------------------------------------------
	localparam int TOTAL_RAM_BYTES = 2304;
	localparam int IRAM_BYTES      = 256;
	localparam int ONCHIP_EXTERNAL_RAM_BYTES      = 2048;
	localparam int ONCHIP_EXTERNAL_RAM_AW         = 11;
	localparam int PAGE_STACK_LEN  = 3;

	// ------------------------------------------------------------
	// Internal RAM regions
	// ------------------------------------------------------------
	localparam logic [7:0] LOWER_RAM_TOP = 8'h7f;
	localparam logic [7:0] BANK_BASE     = 8'h00;
	localparam logic [7:0] BANK_TOP      = 8'h1f;
	localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
	localparam logic [7:0] BIT_BYTE_TOP  = 8'h2f;
	localparam int         BANK_SEL_LSB  = 3;

	// ------------------------------------------------------------
	// Page register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PAGE_CONTROL = 8'h84;
	localparam logic [7:0] ADDR_STACK_NEXT   = 8'h85;
	localparam logic [7:0] ADDR_STACK_LAST   = 8'h86;
	localparam logic [7:0] ADDR_PAGE_SELECT  = 8'ha7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PAGE_CONTROL_RST = 8'h00;
	localparam logic [7:0] PAGE_ENTRY_RST   = 8'h00;
	localparam logic [7:0] IRAM_RST         = 8'h00;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {DMSPS_MODE_DIRECT, DMSPS_MODE_INDIRECT, DMSPS_MODE_BIT}
		dmsps_mode_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		dmsps_mode_t mode;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} dmsps_iacc_t;

	typedef struct packed {
		logic         rd;
		logic         wr;
		logic         code;
		logic [15:0]  addr;
		logic [7:0]   wdata;
	} dmsps_xacc_t;

endpackage
`default_nettype wire

// File: logic/dmsps_top.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Provide 256 internal RAM bytes plus 2048 on-chip external-space bytes.
// - Lower 128 bytes reachable by direct and indirect addressing.
// - Bytes 0x00-0x1f form four banks of eight registers.
// - Bytes 0x20-0x2f accessible as bytes or 128 direct bits.
// - Upper 128 bytes indirect only, separate from special registers.
// - Above 0x7f: direct goes to special registers, indirect to upper RAM.
// - External moves hit on-chip RAM, or program flash when redirected.
// - Page context is a three-entry stack: select, second, third.
// - Software writes change one entry only; only interrupts shift.
// - Third entry write moves into second on return; reads return it.
// - Third entry is eight bits, read/write, zero at reset, all pages.
module dmsps_top
	import dmsps_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Internal data access from core
	input  wire dmsps_iacc_t iacc,
	input  wire logic        bank_sel_in,
	input  wire logic [1:0]  reg_bank,
	output logic      [7:0]  iacc_rdata,
	output logic             iacc_bit,
	// Special register space outside this block
	output logic             sfr_rd,
	output logic             sfr_wr,
	output logic      [7:0]  sfr_addr,
	output logic      [7:0]  sfr_wdata,
	input  wire logic [7:0]  sfr_rdata,
	// External-space moves
	input  wire dmsps_xacc_t xacc,
	input  wire logic        flash_write_en,
	output logic      [7:0]  xacc_rdata,
	output logic             flash_wr,
	output logic             flash_rd,
	output logic      [15:0] flash_addr,
	output logic      [7:0]  flash_wdata,
	input  wire logic [7:0]  flash_rdata,
	// Interrupt context events
	input  wire logic        irq_enter,
	input  wire logic        irq_return,
	output logic      [7:0]  page_selector_top
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] iram [IRAM_BYTES];
	logic [7:0] onchip_external_ram [ONCHIP_EXTERNAL_RAM_BYTES];
	logic [7:0] page_stack [PAGE_STACK_LEN];
	logic [7:0] page_control_reg;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Bit address: low half is RAM 0x20-0x2f, high half is special space
	function automatic logic [7:0] bit_byte(input logic [7:0] a);
		if (!a[7])
			bit_byte = BIT_BYTE_BASE | {4'h0, a[6:3]};
		else
			bit_byte = {a[7:3], 3'h0};
	endfunction

	function automatic logic is_stack_reg(input logic [7:0] a);
		is_stack_reg = (a == ADDR_PAGE_SELECT) || (a == ADDR_STACK_NEXT)
			|| (a == ADDR_STACK_LAST) || (a == ADDR_PAGE_CONTROL);
	endfunction

	logic [7:0] byte_addr;
	logic [7:0] ram_addr;
	logic       to_sfr;
	logic       ram_rd;
	logic       ram_wr;
	logic [7:0] ram_word;
	logic [7:0] ram_wbyte;
	logic [7:0] local_rdata;

	always_comb
	begin
		byte_addr = (iacc.mode == DMSPS_MODE_BIT) ? bit_byte(iacc.addr) : iacc.addr;
		// Indirect above 0x7f lands in upper RAM, direct in special space
		to_sfr = (byte_addr > LOWER_RAM_TOP) && (iacc.mode != DMSPS_MODE_INDIRECT);
		// Register operands R0-relocate into the selected bank; pointers never do
		if (bank_sel_in && (iacc.mode == DMSPS_MODE_DIRECT) && (iacc.addr[7:BANK_SEL_LSB] == 5'h00))
			ram_addr = BANK_BASE | {3'h0, reg_bank, iacc.addr[2:0]};
		else
			ram_addr = byte_addr;
		ram_rd = iacc.rd && !to_sfr;
		ram_wr = iacc.wr && !to_sfr;
		ram_word = iram[ram_addr];
		ram_wbyte = iacc.wdata;
		if (iacc.mode == DMSPS_MODE_BIT)
		begin
			ram_wbyte = ram_word;
			ram_wbyte[iacc.addr[2:0]] = iacc.wdata[0];
		end
	end

	// ------------------------------------------------------------
	// Internal RAM
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < IRAM_BYTES; i++)
				iram[i] <= IRAM_RST;
		end
		else if (ram_wr)
			iram[ram_addr] <= ram_wbyte;
	end

	// ------------------------------------------------------------
	// Page stack
	// ------------------------------------------------------------
	logic stack_wr;
	assign stack_wr = iacc.wr && to_sfr && (iacc.mode != DMSPS_MODE_BIT)
		&& is_stack_reg(byte_addr);

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < PAGE_STACK_LEN; i++)
				page_stack[i] <= PAGE_ENTRY_RST;
		end
		else if (irq_enter)
		begin
			page_stack[2] <= page_stack[1];
			page_stack[1] <= page_stack[0];
		end
		else if (irq_return)
		begin
			page_stack[0] <= page_stack[1];
			page_stack[1] <= page_stack[2];
		end
		else if (stack_wr)
		begin
			// Writes touch one entry and never shift
			unique case (byte_addr)
				ADDR_PAGE_SELECT: page_stack[0] <= iacc.wdata;
				ADDR_STACK_NEXT:  page_stack[1] <= iacc.wdata;
				ADDR_STACK_LAST:  page_stack[2] <= iacc.wdata;
				default:          ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			page_control_reg <= PAGE_CONTROL_RST;
		else if (stack_wr && byte_addr == ADDR_PAGE_CONTROL)
			page_control_reg <= iacc.wdata;
	end

	assign page_selector_top = page_stack[0];

	// ------------------------------------------------------------
	// Read return
	// ------------------------------------------------------------
	// Stack registers answer on every page
	always_comb
	begin
		local_rdata = sfr_rdata;
		unique case (byte_addr)
			ADDR_PAGE_SELECT:  local_rdata = page_stack[0];
			ADDR_STACK_NEXT:   local_rdata = page_stack[1];
			ADDR_STACK_LAST:   local_rdata = page_stack[2];
			ADDR_PAGE_CONTROL: local_rdata = page_control_reg;
			default:           local_rdata = sfr_rdata;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			iacc_rdata <= 8'h00;
			iacc_bit   <= 1'b0;
		end
		else if (iacc.rd)
		begin
			iacc_rdata <= to_sfr ? local_rdata : ram_word;
			iacc_bit   <= to_sfr ? local_rdata[iacc.addr[2:0]] : ram_word[iacc.addr[2:0]];
		end
	end

	// Foreign special registers are passed out; the stack ones stay here
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sfr_rd    <= 1'b0;
			sfr_wr    <= 1'b0;
			sfr_addr  <= 8'h00;
			sfr_wdata <= 8'h00;
		end
		else
		begin
			sfr_rd    <= iacc.rd && to_sfr && !is_stack_reg(byte_addr);
			sfr_wr    <= iacc.wr && to_sfr && !is_stack_reg(byte_addr);
			sfr_addr  <= byte_addr;
			sfr_wdata <= iacc.wdata;
		end
	end

	// ------------------------------------------------------------
	// External-space moves
	// ------------------------------------------------------------
	logic [ONCHIP_EXTERNAL_RAM_AW-1:0] xaddr;
	logic               x_to_flash;
	assign xaddr = xacc.addr[ONCHIP_EXTERNAL_RAM_AW-1:0];
	// Redirected writes go to flash; code reads always do
	assign x_to_flash = flash_write_en && xacc.wr && !xacc.code;

	always_ff @(posedge clk)
	begin
		if (resetn && xacc.wr && !xacc.code && !flash_write_en)
			onchip_external_ram[xaddr] <= xacc.wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			xacc_rdata  <= 8'h00;
			flash_wr    <= 1'b0;
			flash_rd    <= 1'b0;
			flash_addr  <= 16'h0000;
			flash_wdata <= 8'h00;
		end
		else
		begin
			flash_wr    <= x_to_flash;
			flash_rd    <= xacc.rd && xacc.code;
			flash_addr  <= xacc.addr;
			flash_wdata <= xacc.wdata;
			if (xacc.rd && !xacc.code)
				xacc_rdata <= onchip_external_ram[xaddr];
		end
	end

	// Flash data goes straight to the core, so it is only sunk here
	logic unused_ok;
	assign unused_ok = ^flash_rdata;

endmodule

`default_nettype wire

// File: sim/dmsps_sfr_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmsps_sfr_model
(
	// Clock
	input wire logic       clk,
	// Special register bus
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] rd_addr,
	output logic     [7:0] sfr_rdata
);
	logic [7:0] regs [128];
	// Own storage, apart from upper RAM
	always_ff @(posedge clk)
		if (sfr_wr)
			regs[sfr_addr[6:0]] <= sfr_wdata;
	assign sfr_rdata = regs[rd_addr[6:0]];
endmodule
`default_nettype wire

// File: sim/dmsps_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dmsps_tb_top
	import dmsps_pkg::*;
;
	localparam dmsps_mode_t D = DMSPS_MODE_DIRECT;
	localparam dmsps_mode_t I = DMSPS_MODE_INDIRECT;
	typedef struct packed {
		dmsps_mode_t wm;
		logic [7:0]  wa;
		dmsps_mode_t rm;
		logic [7:0]  ra;
		logic [7:0]  d;
		logic [7:0]  e;
		logic [2:0]  bk;
	} dmsps_row_t;
	dmsps_row_t  rows [7] = '{'{D, 8'h10, I, 8'h10, 8'h11, 8'h11, 3'h0},
		'{I, 8'h90, I, 8'h90, 8'h22, 8'h22, 3'h0}, '{D, 8'h90, I, 8'h90, 8'h33, 8'h22, 3'h0},
		'{D, 8'hc0, D, 8'hc0, 8'h44, 8'h44, 3'h0}, '{D, 8'h03, I, 8'h13, 8'h66, 8'h66, 3'h6},
		'{I, 8'h04, I, 8'h14, 8'h5c, 8'h00, 3'h6},
		'{D, 8'h28, I, 8'h28, 8'h80, 8'h80, 3'h0}};
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	dmsps_iacc_t iacc = '0;
	dmsps_xacc_t xacc = '0;
	logic        bank_sel = 1'b0;
	logic [1:0]  bank = 2'h0;
	logic        fwe = 1'b0;
	logic        irq_enter = 1'b0;
	logic        irq_return = 1'b0;
	logic [7:0]  iacc_rdata, sfr_addr, sfr_wdata, sfr_rdata, xacc_rdata, flash_wdata, top;
	logic        iacc_bit, sfr_rd, sfr_wr, flash_wr, flash_rd;
	logic [15:0] flash_addr;
	int          bad_count = 0;
	int          comparisons = 0;
	always #25 clk = ~clk;
	dmsps_top dut
	(
		.clk(clk), .resetn(resetn), .iacc(iacc), .bank_sel_in(bank_sel), .reg_bank(bank),
		.iacc_rdata(iacc_rdata), .iacc_bit(iacc_bit), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xacc(xacc),
		.flash_write_en(fwe), .xacc_rdata(xacc_rdata), .flash_wr(flash_wr),
		.flash_rd(flash_rd), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_rdata(8'h00), .irq_enter(irq_enter), .irq_return(irq_return),
		.page_selector_top(top)
	);
	dmsps_sfr_model u_sfr
	(
		.clk(clk), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.rd_addr(iacc.addr), .sfr_rdata(sfr_rdata)
	);
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, s, e);
		end
	endtask
	// Leading wait keeps lowering and raising in separate time steps
	task automatic ia(input logic w, input dmsps_mode_t m, input logic [7:0] a, d);
		@(negedge clk);
		iacc <= '{~w, w, m, a, d};
		@(negedge clk);
		iacc <= '0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		ia(1'b0, D, a, 8'h00);
		chk(iacc_rdata, e);
	endtask
	task automatic xa(input logic w, c, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		xacc <= '{~w, w, c, a, d};
		@(negedge clk);
		xacc <= '0;
	endtask
	task automatic irq(input logic r);
		@(negedge clk);
		irq_enter <= ~r;
		irq_return <= r;
		@(negedge clk);
		irq_enter <= 1'b0;
		irq_return <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge clk);
		bad_count++;
		report_and_stop;
	end
	initial
	begin
		repeat (5) @(negedge clk);
		resetn <= 1'b1;
		foreach (rows[i])
		begin
			{bank_sel, bank} <= rows[i].bk;
			ia(1'b1, rows[i].wm, rows[i].wa, rows[i].d);
			ia(1'b0, rows[i].rm, rows[i].ra, 8'h00);
			chk(iacc_rdata, rows[i].e);
			$display("row %0d done", i);
		end
		ia(1'b0, DMSPS_MODE_BIT, 8'h47, 8'h00);
		chk(iacc_bit, 1'b1);
		ia(1'b0, DMSPS_MODE_BIT, 8'h46, 8'h00);
		chk(iacc_bit, 1'b0);
		ia(1'b1, DMSPS_MODE_BIT, 8'h41, 8'h01);
		rd(8'h28, 8'h82);
		$display("bit test done");
		ia(1'b1, D, ADDR_PAGE_SELECT, 8'h0a);
		ia(1'b1, D, ADDR_STACK_NEXT, 8'h0b);
		ia(1'b1, D, ADDR_STACK_LAST, 8'h0c);
		chk(top, 8'h0a);
		rd(ADDR_STACK_NEXT, 8'h0b);
		rd(ADDR_STACK_LAST, 8'h0c);
		irq(1'b0);
		chk(top, 8'h0a);
		rd(ADDR_STACK_NEXT, 8'h0a);
		rd(ADDR_STACK_LAST, 8'h0b);
		ia(1'b1, D, ADDR_PAGE_SELECT, 8'h0d);
		chk(top, 8'h0d);
		ia(1'b1, D, ADDR_STACK_LAST, 8'h5a);
		irq(1'b1);
		chk(top, 8'h0a);
		rd(ADDR_STACK_NEXT, 8'h5a);
		rd(ADDR_STACK_LAST, 8'h5a);
		$display("stack test done");
		xa(1'b1, 1'b0, 16'h07ff, 8'h77);
		fwe <= 1'b1;
		xa(1'b1, 1'b0, 16'h07ff, 8'h55);
		chk({flash_wr, flash_wdata}, 9'h155);
		chk(flash_addr, 16'h07ff);
		xa(1'b0, 1'b1, 16'h0100, 8'h00);
		chk(flash_rd, 1'b1);
		fwe <= 1'b0;
		xa(1'b0, 1'b0, 16'h07ff, 8'h00);
		chk(xacc_rdata, 8'h77);
		$display("external test done");
		resetn <= 1'b0;
		@(negedge clk);
		resetn <= 1'b1;
		chk(top, 8'h00);
		rd(ADDR_STACK_LAST, 8'h00);
		$display("reset test done");
		report_and_stop;
	end
endmodule
`default_nettype wire

// File: sim/dmsps_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module dmsps_top_props
	import dmsps_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Requests
	input wire dmsps_iacc_t iacc,
	input wire dmsps_xacc_t xacc,
	input wire logic        flash_write_en,
	input wire logic        irq_enter,
	input wire logic        irq_return,
	// Responses
	input wire logic        sfr_rd,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_addr,
	input wire logic        flash_wr,
	input wire logic        flash_rd,
	input wire logic [7:0]  page_selector_top
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic dhi;
	logic dir;
	assign dir = iacc.mode == DMSPS_MODE_DIRECT;
	// Page registers stay local, so they never reach the outer bus
	assign dhi = dir && iacc.addr[7] && !(iacc.addr inside {ADDR_PAGE_CONTROL,
		ADDR_STACK_NEXT, ADDR_STACK_LAST, ADDR_PAGE_SELECT});
	chk_sfr_write: assert property (iacc.wr && dhi |=> sfr_wr && sfr_addr == $past(iacc.addr))
		else $error("direct write not forwarded");
	chk_sfr_read: assert property (iacc.rd && dhi |=> sfr_rd)
		else $error("direct read not forwarded");
	chk_upper_local: assert property ((iacc.rd || iacc.wr) && iacc.mode == DMSPS_MODE_INDIRECT
		|=> !sfr_rd && !sfr_wr)
		else $error("indirect access leaked");
	chk_select_local: assert property (iacc.wr && dir && iacc.addr == ADDR_PAGE_SELECT
		&& !irq_enter && !irq_return |=> !sfr_wr && page_selector_top == $past(iacc.wdata))
		else $error("page select write wrong");
	chk_flash_redirect: assert property (xacc.wr && !xacc.code && flash_write_en |=> flash_wr)
		else $error("flash write missing");
	chk_onchip_external_ram_kept: assert property (xacc.wr && !flash_write_en |=> !flash_wr)
		else $error("flash write spurious");
	chk_code_read: assert property (xacc.rd && xacc.code |=> flash_rd)
		else $error("code read missing");
	chk_push_top: assert property (irq_enter |=> $stable(page_selector_top))
		else $error("push changed top");
	chk_reset_clear: assert property (disable iff (1'b0) !resetn
		|=> page_selector_top == 8'h00 && !sfr_wr && !flash_wr)
		else $error("reset not clean");
	cover property (irq_enter);
	cover property (irq_return);
	cover property (sfr_wr);
endmodule
bind dmsps_top dmsps_top_props u_props
(
	.clk(clk), .resetn(resetn), .iacc(iacc), .xacc(xacc),
	.flash_write_en(flash_write_en), .irq_enter(irq_enter), .irq_return(irq_return),
	.sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .flash_wr(flash_wr),
	.flash_rd(flash_rd), .page_selector_top(page_selector_top)
);
`default_nettype wire
